// ### common/ccd_params.svh
// Constants of the clock select and divider block
`ifndef CCD_PARAMS_SVH
`define CCD_PARAMS_SVH
// Clock source select codes (3-bit field)
`define CCD_SRC_XTAL_LO  3'h0
`define CCD_SRC_XTAL_MED 3'h1
`define CCD_SRC_XTAL_HI  3'h2
`define CCD_SRC_RC       3'h3
`define CCD_SRC_WDT      3'h4
`define CCD_SRC_EXT      3'h7
// Field positions in the clock control write data
`define CCD_CC_SRC_MSB   2
`define CCD_CC_DBL_BIT   3
`define CCD_CC_XWD_BIT   4
// Field positions in the trim write data
`define CCD_TRIM_MSB     5
`define CCD_TRIM_EN_BIT  6
// Config byte bits copied at reset
`define CCD_USER_CONFIG_BYTE_ONE_SRC_MSB 2
`define CCD_USER_CONFIG_BYTE_TWO_DBL_BIT 7
// Reset values
`define CCD_TRIM_RST     6'h00
`define CCD_DIV_CNT_RST  9'h000
`define CCD_WCNT_RST     14'h0000
// Wake-up timing
`define CCD_CLK_MHZ      50
`define CCD_XTAL_OSC_CYC 1024
`define CCD_SLOW_OSC_CYC 32
`define CCD_XTAL_US      60
`define CCD_RC_US        200
`define CCD_XTAL_CYC     (`CCD_XTAL_US * `CCD_CLK_MHZ)
`define CCD_RC_CYC       (`CCD_RC_US * `CCD_CLK_MHZ)
// Memory map limits
`define CCD_DIRECT_TOP   16'h0080
`define CCD_XRAM_TOP     16'h0200
`define CCD_XSFR_BASE    16'hff00
`define CCD_CODE_TOP     16'h2000
`endif

// ### common/ccd_pkg.sv
// Types of the clock select and divider block
`default_nettype none

package ccd_pkg;
  // Wake-up sequencer states
  typedef enum logic [1:0] {
    WAKE_OSC,
    WAKE_US,
    WAKE_RUN
  } ccd_wake_type;

  // Kind of CPU memory access
  typedef enum logic [1:0] {
    MEM_DIRECT,
    MEM_INDIRECT,
    MEM_EXTERNAL,
    MEM_CODE
  } ccd_mem_mode_type;

  // Where a memory access lands
  typedef struct packed {
    logic data_ram;
    logic sfr;
    logic external_data_space_ram;
    logic external_data_space_sfr;
    logic code_chip;
    logic ext_bus;
  } ccd_mem_hit_type;

  // Whole block state
  typedef struct packed {
    ccd_wake_type    wake;
    logic [2:0]      src;
    logic            dbl;
    logic            xwd;
    logic [5:0]      trim;
    logic            clkout_en;
    logic            lp;
    logic [8:0]      div_cnt;
    logic [13:0]     wcnt;
    logic            cpu_en;
    logic            per_ph;
    logic            per_en;
    logic            clk_out;
    ccd_mem_hit_type hit;
  } ccd_state_type;
endpackage : ccd_pkg

`default_nettype wire

// ### hdl/ccd_clock_ctrl.sv
// Clock source select, wake-up timer, divider and memory map decode
//
// Overview of operation
// R1: Machine cycle spans two cpu clocks
// R2: Peripheral clock is cpu clock halved
// R3: Osc clock chosen from four sources
// R4: RC runs 7.373 MHz, doubled 14.746 MHz
// R5: Six-bit trim loaded at reset, writable
// R6: Clock out only if crystal unused
// R7: Clock out toggles at half cpu rate
// R8: Crystal usable for osc, RTC, watchdog
// R9: Switch done clears, sets when finished
// R10: Control writes refused while switching
// R11: Crystal wake: 1024 osc plus 60us
// R12: RC wake: 200 to 300 us
// R13: Watchdog or external wake: 32 osc
// R14: Programmable divider, ratio up to 510
// R15: Divider changes ratio without stall
// R16: Low power select resets to zero
// R17: Brownout bits set for fast clocks; this block has no brownout bits
// R18: Low data direct, all indirect
// R19: Special registers direct only
// R20: External space: 512 bytes, ext SFRs
// R21: Code 64 kB, 8 kB on chip
// R22: Trim reloads on power-on, watchdog only
// R23: Source, doubler loaded from config bytes
// R24: Zero passes, else divide by twice
`timescale 1ns/1ps
`default_nettype none
`include "ccd_params.svh"

module ccd_clock_ctrl
  import ccd_pkg::*;
#(
  // RC wake-up hold in system clocks
  parameter int RC_WAKE_CYC = `CCD_RC_CYC
) (
  input  wire logic             clock_i,
  input  wire logic             reset_i,
  input  wire logic             por_wdt_reset_i,
  input  wire logic [7:0]       user_config_one_i,
  input  wire logic [7:0]       user_config_two_i,
  input  wire logic [5:0]       factory_trim_i,
  input  wire logic             xtal_tick_i,
  input  wire logic             rc_tick_i,
  input  wire logic             wdt_tick_i,
  input  wire logic             ext_tick_i,
  input  wire logic             clock_control_reg_wr_i,
  input  wire logic [7:0]       clock_control_reg_wdata_i,
  input  wire logic             trim_wr_i,
  input  wire logic [6:0]       trim_wdata_i,
  input  wire logic             lp_wr_i,
  input  wire logic             lp_wdata_i,
  input  wire logic [7:0]       clock_divide_value_i,
  input  wire logic             mem_req_i,
  input  wire ccd_mem_mode_type mem_mode_i,
  input  wire logic [15:0]      mem_addr_i,
  output logic                  cpu_clock_en_o,
  output logic                  periph_clock_en_o,
  output logic                  machine_cycle_en_o,
  output logic                  clock_switch_done_o,
  output logic [2:0]            osc_select_o,
  output logic                  rc_doubler_o,
  output logic                  xtal_for_rtc_wdt_o,
  output logic [5:0]            rc_trim_value_o,
  output logic                  clock_out_enable_o,
  output logic                  low_power_clock_select_o,
  output logic                  xtal_out_clock_o,
  output logic                  xtal_out_clock_oe_n_o,
  output var ccd_mem_hit_type   mem_hit_o
);

  ccd_state_type state_r;    // Registered state
  ccd_state_type state_nxt;  // Next state
  logic          osc_tick;   // Selected osc clock pulse
  logic          clkout_ok;  // Clock out may drive pin
  logic [2:0]    new_src;    // Requested source

  // True for any of the three crystal speeds
  function automatic logic is_xtal(input logic [2:0] src);
    is_xtal = (src == `CCD_SRC_XTAL_LO) ||
              (src == `CCD_SRC_XTAL_MED) ||
              (src == `CCD_SRC_XTAL_HI);
  endfunction : is_xtal

  // Picks the osc clock pulse of a source
  function automatic logic sel_tick(input logic [2:0] src,
                                    input logic [3:0] ticks);
    if (is_xtal(src)) begin
      sel_tick = ticks[0];  // see R3, see R8
    end else if (src == `CCD_SRC_WDT) begin
      sel_tick = ticks[2];
    end else if (src == `CCD_SRC_EXT) begin
      sel_tick = ticks[3];
    end else begin
      // Unused codes fall back to the RC oscillator
      sel_tick = ticks[1];
    end
  endfunction : sel_tick

  // Osc clock cycles of the wake-up hold
  function automatic logic [13:0] wake_osc(input logic [2:0] src);
    if (is_xtal(src)) begin
      wake_osc = 14'(`CCD_XTAL_OSC_CYC);  // see R11
    end else if (src == `CCD_SRC_WDT || src == `CCD_SRC_EXT) begin
      wake_osc = 14'(`CCD_SLOW_OSC_CYC);  // see R13
    end else begin
      wake_osc = 14'h0000;
    end
  endfunction : wake_osc

  // System clocks of the extra wake-up hold
  function automatic logic [13:0] wake_us(input logic [2:0] src);
    if (is_xtal(src)) begin
      wake_us = 14'(`CCD_XTAL_CYC);  // see R11
    end else if (src == `CCD_SRC_WDT || src == `CCD_SRC_EXT) begin
      wake_us = 14'h0000;
    end else begin
      wake_us = 14'(RC_WAKE_CYC);  // see R12
    end
  endfunction : wake_us

  // Memory map decode of one access
  function automatic ccd_mem_hit_type decode(
    input ccd_mem_mode_type mode,
    input logic [15:0]      addr);
    ccd_mem_hit_type h;
    h = '0;
    case (mode)
      MEM_DIRECT: begin
        // Upper direct half is the SFR space
        h.data_ram = (addr < `CCD_DIRECT_TOP);  // see R18
        h.sfr      = (addr >= `CCD_DIRECT_TOP) &&
                     (addr[15:8] == 8'h00);     // see R19
      end
      MEM_INDIRECT: begin
        // Indirect never reaches SFRs
        h.data_ram = (addr[15:8] == 8'h00);     // see R18, see R19
      end
      MEM_EXTERNAL: begin
        h.external_data_space_ram = (addr < `CCD_XRAM_TOP);   // see R20
        h.external_data_space_sfr = (addr >= `CCD_XSFR_BASE); // see R20
        h.ext_bus   = !h.external_data_space_ram && !h.external_data_space_sfr;
      end
      MEM_CODE: begin
        h.code_chip = (addr < `CCD_CODE_TOP);   // see R21
        h.ext_bus   = !h.code_chip;
      end
      default: begin
        h = '0;
      end
    endcase
    decode = h;
  endfunction : decode

  // Source pulse and clock out permission
  always_comb begin
    osc_tick  = sel_tick(state_r.src, {ext_tick_i, wdt_tick_i,
                                       rc_tick_i, xtal_tick_i});
    // Pin belongs to the crystal whenever anyone uses it
    clkout_ok = state_r.clkout_en && !is_xtal(state_r.src) &&
                !state_r.xwd;  // see R6
    new_src   = clock_control_reg_wdata_i[`CCD_CC_SRC_MSB:0];
  end

  // Next state of the whole block
  always_comb begin
    state_nxt        = state_r;
    state_nxt.cpu_en = 1'b0;
    state_nxt.per_en = 1'b0;
    if (reset_i) begin
      // Every reset restarts the wake-up hold
      state_nxt.wake    = WAKE_OSC;
      state_nxt.src     =
        user_config_one_i[`CCD_USER_CONFIG_BYTE_ONE_SRC_MSB:0];  // see R23
      state_nxt.dbl     =
        user_config_two_i[`CCD_USER_CONFIG_BYTE_TWO_DBL_BIT];    // see R23, see R4
      state_nxt.xwd     = 1'b0;
      state_nxt.lp      = 1'b0;  // see R16
      state_nxt.div_cnt = `CCD_DIV_CNT_RST;
      state_nxt.wcnt    = `CCD_WCNT_RST;
      state_nxt.per_ph  = 1'b0;
      state_nxt.clk_out = 1'b0;
      state_nxt.hit     = '0;
      // Other resets keep the tuned trim
      if (por_wdt_reset_i) begin
        state_nxt.trim      = factory_trim_i;  // see R5, see R22
        state_nxt.clkout_en = 1'b0;
      end
    end else begin
      case (state_r.wake)
        WAKE_OSC: begin
          // Count osc cycles of the new source
          if (wake_osc(state_r.src) == 14'h0000) begin
            state_nxt.wake = WAKE_US;
          end else if (osc_tick) begin
            if (state_r.wcnt + 14'h0001 >= wake_osc(state_r.src))
            begin
              state_nxt.wcnt = `CCD_WCNT_RST;
              state_nxt.wake = WAKE_US;
            end else begin
              state_nxt.wcnt = state_r.wcnt + 14'h0001;
            end
          end
        end
        WAKE_US: begin
          // Extra hold counted on the system clock
          if (state_r.wcnt + 14'h0001 >= wake_us(state_r.src)) begin
            state_nxt.wcnt = `CCD_WCNT_RST;
            state_nxt.wake = WAKE_RUN;  // see R9
          end else begin
            state_nxt.wcnt = state_r.wcnt + 14'h0001;
          end
        end
        WAKE_RUN: begin
          // Divider compares live, so a new ratio
          // takes effect at once without a stall
          if (osc_tick) begin
            if (clock_divide_value_i == 8'h00) begin
              state_nxt.cpu_en  = 1'b1;  // see R24
              state_nxt.div_cnt = `CCD_DIV_CNT_RST;
            end else if (state_r.div_cnt + 9'h001 >=
                         {clock_divide_value_i, 1'b0}) begin
              state_nxt.cpu_en  = 1'b1;  // see R14, see R24
              state_nxt.div_cnt = `CCD_DIV_CNT_RST;
            end else begin
              state_nxt.div_cnt = state_r.div_cnt + 9'h001;  // see R15
            end
          end
        end
        default: begin
          state_nxt.wake = WAKE_OSC;
        end
      endcase

      // Half-rate phase for peripherals and machine cycles
      if (state_nxt.cpu_en) begin
        state_nxt.per_ph = !state_r.per_ph;
        state_nxt.per_en = state_r.per_ph;  // see R1, see R2
        // Toggle per cpu clock gives half its rate
        state_nxt.clk_out = clkout_ok && !state_r.clk_out;  // see R7
      end else if (!clkout_ok) begin
        state_nxt.clk_out = 1'b0;
      end

      // Control writes only while no switch runs
      if (clock_control_reg_wr_i && state_r.wake == WAKE_RUN) begin  // see R10
        state_nxt.dbl = clock_control_reg_wdata_i[`CCD_CC_DBL_BIT];
        state_nxt.xwd = clock_control_reg_wdata_i[`CCD_CC_XWD_BIT];  // see R8
        if (new_src != state_r.src) begin
          // Start a switch: done drops next cycle
          state_nxt.src     = new_src;  // see R9
          state_nxt.wake    = WAKE_OSC;
          state_nxt.wcnt    = `CCD_WCNT_RST;
          state_nxt.div_cnt = `CCD_DIV_CNT_RST;
        end
      end

      // Trim and clock out enable share one write
      if (trim_wr_i) begin
        state_nxt.trim      = trim_wdata_i[`CCD_TRIM_MSB:0];  // see R5
        state_nxt.clkout_en = trim_wdata_i[`CCD_TRIM_EN_BIT];
      end

      // Software owns the low power rate check
      if (lp_wr_i) begin
        state_nxt.lp = lp_wdata_i;  // see R16
      end

      // Memory space decode, one cycle latency
      if (mem_req_i) begin
        state_nxt.hit = decode(mem_mode_i, mem_addr_i);
      end else begin
        state_nxt.hit = '0;
      end
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    state_r <= state_nxt;
  end

  // Outputs straight from the state
  always_comb begin
    cpu_clock_en_o           = state_r.cpu_en;
    periph_clock_en_o        = state_r.per_en;
    machine_cycle_en_o       = state_r.per_en;  // see R1
    clock_switch_done_o      = (state_r.wake == WAKE_RUN);  // see R9
    osc_select_o             = state_r.src;
    rc_doubler_o             = state_r.dbl;  // see R4
    xtal_for_rtc_wdt_o       = state_r.xwd;
    rc_trim_value_o          = state_r.trim;
    clock_out_enable_o       = state_r.clkout_en;
    low_power_clock_select_o = state_r.lp;
    xtal_out_clock_o         = state_r.clk_out;
    xtal_out_clock_oe_n_o    = !clkout_ok;  // see R6
    mem_hit_o                = state_r.hit;
  end

endmodule : ccd_clock_ctrl

`default_nettype wire

// ### verification/ccd_osc_src.sv
// Behavioural crystal or external clock source feeding the tick inputs
`timescale 1ns/1ps
`default_nettype none

module ccd_osc_src #(
  parameter int PERIOD = 4  // System clocks per oscillator cycle
) (
  input  wire logic clock_i,
  input  wire logic run_i,
  output var  logic tick_o
);
  int cnt_r = 0;  // Phase inside one oscillator cycle

  initial tick_o = 1'b0;

  // One pulse per cycle; a stopped source stands still, so no ticks leak
  always @(posedge clock_i) begin
    cnt_r  <= run_i ? (cnt_r + 1) % PERIOD : cnt_r;
    tick_o <= run_i && cnt_r == PERIOD - 1;
  end
endmodule : ccd_osc_src

`default_nettype wire

// ### verification/ccd_clock_ctrl_monitor.sv
// Concurrent checks on the clock control block's ports
`timescale 1ns/1ps
`default_nettype none

module ccd_clock_ctrl_monitor
  import ccd_pkg::*;
(
  input wire logic             clock_i,
  input wire logic             reset_i,
  input wire logic             clock_control_reg_wr_i,
  input wire logic [7:0]       clock_control_reg_wdata_i,
  input wire logic             trim_wr_i,
  input wire logic [6:0]       trim_wdata_i,
  input wire logic             mem_req_i,
  input wire ccd_mem_mode_type mem_mode_i,
  input wire logic [15:0]      mem_addr_i,
  input wire logic             cpu_clock_en_o,
  input wire logic             periph_clock_en_o,
  input wire logic             machine_cycle_en_o,
  input wire logic             clock_switch_done_o,
  input wire logic [2:0]       osc_select_o,
  input wire logic             xtal_for_rtc_wdt_o,
  input wire logic [5:0]       rc_trim_value_o,
  input wire logic             clock_out_enable_o,
  input wire logic             low_power_clock_select_o,
  input wire logic             xtal_out_clock_o,
  input wire logic             xtal_out_clock_oe_n_o,
  input wire ccd_mem_hit_type  mem_hit_o
);
  // All checks live in the one system clock domain
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);

  a_periph_on_cpu: assert property (
      periph_clock_en_o |-> cpu_clock_en_o)
    else $error("periph pulse without cpu pulse");
  a_mcycle_match: assert property (
      machine_cycle_en_o == periph_clock_en_o)
    else $error("machine cycle pulse off periph pulse");
  a_clkout_gate: assert property (
      !xtal_out_clock_oe_n_o == (clock_out_enable_o &&
      osc_select_o > 3'h2 && !xtal_for_rtc_wdt_o))
    else $error("clock out drive condition wrong");
  // Two cycles into a switch no cpu pulse may be left in flight
  a_hold_no_cpu: assert property (!clock_switch_done_o &&
      !$past(clock_switch_done_o) |-> !cpu_clock_en_o)
    else $error("cpu pulse while switching");
  a_refuse_write: assert property (
      clock_control_reg_wr_i && !clock_switch_done_o
      |=> $stable(osc_select_o) && $stable(xtal_for_rtc_wdt_o))
    else $error("control write taken while switching");
  a_switch_start: assert property (
      clock_control_reg_wr_i && clock_switch_done_o &&
      clock_control_reg_wdata_i[2:0] != osc_select_o |=> !clock_switch_done_o &&
      osc_select_o == $past(clock_control_reg_wdata_i[2:0]) ##1 !clock_switch_done_o)
    else $error("switch did not start");
  a_trim_write: assert property (trim_wr_i |=>
      {clock_out_enable_o, rc_trim_value_o} == $past(trim_wdata_i))
    else $error("trim write lost");
  a_lp_reset: assert property (
      $past(reset_i) |-> !low_power_clock_select_o)
    else $error("low power select set after reset");
  a_direct_low: assert property (
      mem_req_i && mem_mode_i == MEM_DIRECT &&
      mem_addr_i < 16'h0080 |=> mem_hit_o == 6'h20)
    else $error("direct low address not data ram");
  a_sfr_direct: assert property (
      mem_hit_o.sfr |-> $past(mem_req_i) &&
      $past(mem_mode_i) == MEM_DIRECT)
    else $error("sfr hit without direct access");

  c_switch_done: cover property ($rose(clock_switch_done_o));
  c_sfr_hit: cover property (mem_hit_o.sfr);
  c_clkout_on: cover property (!xtal_out_clock_oe_n_o && $rose(xtal_out_clock_o));
endmodule : ccd_clock_ctrl_monitor

`default_nettype wire

// ### verification/test_clock_select_divider_memmap.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
`default_nettype none

module test_clock_select_divider_memmap;
  import ccd_pkg::*;
  localparam int P = 4;  // System clocks per crystal tick
  // Decode rows: mode, address, expected hit
  localparam logic [23:0] ROWS [8] = '{{2'h0, 16'h007f, 6'h20},
    {2'h0, 16'h0080, 6'h10}, {2'h1, 16'h00ff, 6'h20},
    {2'h2, 16'h01ff, 6'h08}, {2'h2, 16'h0200, 6'h01},
    {2'h2, 16'hff00, 6'h04}, {2'h3, 16'h1fff, 6'h02},
    {2'h3, 16'h2000, 6'h01}};
  localparam logic [7:0] DIVS [4] = '{8'h00, 8'h01, 8'h05, 8'hff};
  logic clock_i, reset_i, por_wdt_reset_i, xtal_tick_i, rc_tick_i;
  logic wdt_tick_i, ext_tick_i, clock_control_reg_wr_i, trim_wr_i, lp_wr_i;
  logic lp_wdata_i, mem_req_i, cpu_clock_en_o, periph_clock_en_o;
  logic machine_cycle_en_o, clock_switch_done_o, rc_doubler_o;
  logic xtal_for_rtc_wdt_o, clock_out_enable_o, low_power_clock_select_o;
  logic xtal_out_clock_o, xtal_out_clock_oe_n_o;
  logic [7:0]       user_config_one_i, user_config_two_i;
  logic [7:0]       clock_control_reg_wdata_i, clock_divide_value_i;
  logic [5:0]       factory_trim_i, rc_trim_value_o;
  logic [6:0]       trim_wdata_i;
  logic [15:0]      mem_addr_i;
  logic [2:0]       osc_select_o, mon;
  ccd_mem_mode_type mem_mode_i;
  ccd_mem_hit_type  mem_hit_o;
  int               fail_count, compares, n, cyc;

  ccd_clock_ctrl #(.RC_WAKE_CYC(20)) i_dut (.*);
  ccd_osc_src #(.PERIOD(P)) i_osc (.clock_i(clock_i), .run_i(1'b1),
    .tick_o(xtal_tick_i));
  assign ext_tick_i = xtal_tick_i;  // Crystal and external share a pin
  assign mon = {xtal_out_clock_o, periph_clock_en_o, cpu_clock_en_o};

  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end

  // RC ticks every 2 clocks, watchdog ticks every 3
  always @(posedge clock_i) begin
    cyc        <= cyc + 1;
    rc_tick_i  <= cyc[0];
    wdt_tick_i <= cyc % 3 == 0;
  end

  task end_of_test;
    if (fail_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // One settled sample; a hang counts as a mismatch
  task step(inout int c);
    @(negedge clock_i);
    c++;
    if (c > 9000) begin
      fail_count++;
      end_of_test;
    end
  endtask : step

  // Clocks between two rising edges of a watched output
  task gap(input int s, output int c);
    for (int k = 0; k < 2; k++) begin
      c = 0;
      while (mon[s] !== 1'b0) step(c);
      while (mon[s] !== 1'b1) step(c);
    end
  endtask : gap

  // First step lets a write taken at this edge land
  task wait_done(output int c);
    c = 0;
    step(c);
    while (clock_switch_done_o !== 1'b1) step(c);
  endtask : wait_done

  // One-cycle write strobe: bit 0 control, bit 1 trim, bit 2 low power
  task wr(input logic [2:0] w, input logic [7:0] v);
    @(posedge clock_i);
    {lp_wr_i, trim_wr_i, clock_control_reg_wr_i} <= w;
    clock_control_reg_wdata_i <= v;
    trim_wdata_i   <= v[6:0];
    lp_wdata_i     <= v[0];
    @(posedge clock_i);
    {lp_wr_i, trim_wr_i, clock_control_reg_wr_i} <= 3'h0;
  endtask : wr

  initial begin
    fail_count = 0;
    compares = 0;
    {reset_i, por_wdt_reset_i} = 2'h3;
    {clock_control_reg_wr_i, trim_wr_i, lp_wr_i} = 3'h0;
    {lp_wdata_i, mem_req_i} = 2'h0;
    // Doubler on and external source taken from the config bytes
    user_config_one_i = 8'h2f;
    user_config_two_i = 8'h80;
    factory_trim_i = 6'h2a;
    clock_control_reg_wdata_i = 8'h00;
    trim_wdata_i = 7'h00;
    clock_divide_value_i = 8'h00;
    mem_addr_i = 16'h0000;
    mem_mode_i = MEM_DIRECT;
    repeat (16) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk(16'({osc_select_o, rc_doubler_o, clock_switch_done_o}),
      16'h001e);
    chk(16'({low_power_clock_select_o, clock_out_enable_o, rc_trim_value_o}),
      16'h002a);
    wait_done(n);
    chk(16'(n >= 31 * P && n <= 33 * P + 4), 16'h0001);
    // Back-to-back decode requests, result checked one cycle on
    for (int k = 0; k < 10; k++) begin
      @(posedge clock_i);
      mem_req_i  <= k < 8;
      mem_mode_i <= ccd_mem_mode_type'(ROWS[k % 8][23:22]);
      mem_addr_i <= ROWS[k % 8][21:6];
      @(negedge clock_i);
      if (k > 0) chk(16'(mem_hit_o),
        k < 9 ? 16'(ROWS[k - 1][5:0]) : 16'h0);
    end
    // Divider ratios, first gap after a change skipped
    foreach (DIVS[i]) begin
      @(posedge clock_i);
      clock_divide_value_i <= DIVS[i];
      gap(0, n);
      gap(0, n);
      chk(16'(n), 16'(DIVS[i] == 0 ? P : 2 * P * DIVS[i]));
      gap(1, n);
      chk(16'(n), 16'(DIVS[i] == 0 ? 2 * P : 4 * P * DIVS[i]));
    end
    @(posedge clock_i);
    clock_divide_value_i <= 8'h01;
    wr(3'h2, 8'h55);
    @(negedge clock_i);
    chk(16'({clock_out_enable_o, rc_trim_value_o, xtal_out_clock_oe_n_o}),
      16'h00aa);
    gap(2, n);
    chk(16'(n), 16'(4 * P));
    wr(3'h1, 8'h17);
    @(negedge clock_i);
    chk(16'({xtal_out_clock_oe_n_o, xtal_for_rtc_wdt_o, clock_switch_done_o}),
      16'h0007);
    // Crystal switch; second write lands while switching and is refused
    wr(3'h1, 8'h02);
    wr(3'h1, 8'h04);
    @(negedge clock_i);
    chk(16'({clock_switch_done_o, osc_select_o, xtal_out_clock_oe_n_o}),
      16'h0005);
    wait_done(n);
    chk(16'(n >= 1024 * P + 2990 && n <= 1024 * P + 3010),
      16'h0001);
    gap(0, n);
    chk(16'(n), 16'(2 * P));
    wr(3'h1, 8'h03);
    wait_done(n);
    chk(16'(n >= 18 && n <= 26), 16'h0001);
    gap(0, n);
    chk(16'(n), 16'h0004);
    wr(3'h1, 8'h04);
    wait_done(n);
    chk(16'(n >= 93 && n <= 102), 16'h0001);
    gap(0, n);
    chk(16'(n), 16'h0006);
    wr(3'h4, 8'h01);
    @(negedge clock_i);
    chk(16'(low_power_clock_select_o), 16'h0001);
    // Warm reset keeps trim and clock out enable
    @(posedge clock_i);
    {reset_i, por_wdt_reset_i} <= 2'h2;
    factory_trim_i <= 6'h3f;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    @(negedge clock_i);
    chk(16'({low_power_clock_select_o, clock_out_enable_o, rc_trim_value_o,
      osc_select_o}), 16'h02af);
    end_of_test;
  end
endmodule : test_clock_select_divider_memmap

bind ccd_clock_ctrl ccd_clock_ctrl_monitor i_mon (.*);

`default_nettype wire
